/* hw/ffmd_axis_compare.sv */
// Per-axis magnitude comparison against the shared threshold
`timescale 1ns/10ps
module ffmd_axis_compare
  import ffmd_pkg::*;
#(
  parameter int SHIFT = SAMPLE_W - 1 - THS_W
)
(
  input ffmd_pkg::ffmd_sample_t sample,
  input wire logic [ffmd_pkg::THS_W-1:0] threshold,
  output ffmd_pkg::ffmd_axis_flags_t flags
);
  import ffmd_pkg::*;

  logic signed [SAMPLE_W-1:0] axis_val [3];
  logic [SAMPLE_W-1:0] axis_mag [3];

  assign axis_val[0] = sample.x;
  assign axis_val[1] = sample.y;
  assign axis_val[2] = sample.z;

  // Threshold scaled to the sample LSB; full-scale 8 g spans 7 bits
  for (genvar i = 0; i < 3; i++)
  begin : g_axis
    assign axis_mag[i] = axis_val[i][SAMPLE_W-1] ? SAMPLE_W'(-axis_val[i])
                                                  : SAMPLE_W'(axis_val[i]);
    assign flags.over[i] = axis_mag[i] > (SAMPLE_W'(threshold) << SHIFT);
    assign flags.neg[i] = axis_val[i][SAMPLE_W-1];
  end

endmodule : ffmd_axis_compare

/* hw/ffmd_event_flags.sv */
// Fall/motion event detection, debounce, latching and register file
`timescale 1ns/10ps

//------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------
module ffmd_event_flags
  import ffmd_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sample_tick,
  input ffmd_pkg::ffmd_sample_t sample,
  input wire logic [ffmd_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ffmd_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ffmd_pkg::DATA_W-1:0] reg_rdata,
  output logic irq_pin1,
  output logic irq_pin2
);
  import ffmd_pkg::*;

  //------------------------------------------------------------
  // Registers
  //------------------------------------------------------------
  logic [DATA_W-1:0] cfg_r;
  logic [DATA_W-1:0] ths_r;
  logic [CNT_W-1:0] dbc_limit_r;
  logic [1:0] irq_ctrl_r;
  logic active_r;
  ffmd_axis_flags_t src_flags_r;
  logic [CNT_W-1:0] dbc_r;
  logic [CNT_W-1:0] dbc_nxt;
  logic [DATA_W-1:0] reg_rdata_r;

  logic latch_on_event_enable;
  logic combine_or_and_choice;
  logic [2:0] axis_en;
  logic debounce_clear_mode;
  logic fall_motion_irq_enable;
  logic fall_motion_irq_pin_route;
  ffmd_axis_flags_t live_flags;
  ffmd_axis_flags_t masked_flags;
  logic condition;
  logic src_read;
  logic latched_hold;
  logic active_nxt;
  logic [CNT_W-1:0] dbc_fresh;
  logic read_tick_set;

  assign latch_on_event_enable = cfg_r[CFG_LATCH_BIT];
  assign combine_or_and_choice = cfg_r[CFG_COMBINE_BIT];
  assign axis_en = {cfg_r[CFG_Z_EN_BIT], cfg_r[CFG_Y_EN_BIT], cfg_r[CFG_X_EN_BIT]};
  assign debounce_clear_mode = ths_r[THS_MODE_BIT];
  assign fall_motion_irq_enable = irq_ctrl_r[IRQ_EN_BIT];
  assign fall_motion_irq_pin_route = irq_ctrl_r[IRQ_ROUTE_BIT];

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    addr_hit = (a == b);
  endfunction : addr_hit

  assign src_read = reg_rd && addr_hit(reg_addr, FALL_MOTION_SOURCE_ADDR);

  //------------------------------------------------------------
  // Detection
  //------------------------------------------------------------
  ffmd_axis_compare u_compare (
    .sample(sample),
    .threshold(ths_r[THS_W-1:0]),
    .flags(live_flags)
  );

  assign masked_flags.over = live_flags.over & axis_en;
  assign masked_flags.neg = live_flags.neg & axis_en;

  // No axis enabled means the function is off in either mode
  always_comb
  begin
    if (axis_en == 3'h0)
      condition = 1'b0;
    else if (combine_or_and_choice)
      condition = |masked_flags.over;
    else
      condition = ~|(live_flags.over & axis_en);
  end

  //------------------------------------------------------------
  // Debounce counter
  //------------------------------------------------------------
  always_comb
  begin
    dbc_nxt = dbc_r;
    if (condition)
    begin
      if (dbc_r < dbc_limit_r)
        dbc_nxt = dbc_r + CNT_W'(1);
      else
        dbc_nxt = dbc_limit_r;
    end
    else if (debounce_clear_mode)
      dbc_nxt = '0;
    else if (dbc_r != '0)
      dbc_nxt = dbc_r - CNT_W'(1);
  end

  assign latched_hold = latch_on_event_enable && active_r;

  // A clearing read restarts the count; a tick in that cycle is its first step
  assign dbc_fresh = (condition && dbc_limit_r != '0) ? CNT_W'(1) : '0;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      dbc_r <= '0;
    else if (src_read && latch_on_event_enable && !sample_tick)
      dbc_r <= '0;
    else if (sample_tick)
      dbc_r <= (src_read && latch_on_event_enable) ? dbc_fresh : dbc_nxt;
  end

  //------------------------------------------------------------
  // Event flag and source flags
  //------------------------------------------------------------
  // Live mode: the event flag tracks the debounced counter
  always_comb
  begin
    active_nxt = active_r;
    if (sample_tick)
    begin
      if (condition && dbc_nxt >= dbc_limit_r)
        active_nxt = 1'b1;
      else if (!latch_on_event_enable && dbc_nxt == '0)
        active_nxt = 1'b0;
      else if (!latch_on_event_enable && debounce_clear_mode)
        active_nxt = 1'b0;
    end
  end

  // A tick that completes the count beside a clearing read still sets the event,
  // so software never loses it; a held event cleared by the read counts afresh
  assign read_tick_set = condition
                         && ((latched_hold ? dbc_fresh : dbc_nxt) >= dbc_limit_r);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      active_r <= 1'b0;
    else if (latched_hold && !src_read)
      active_r <= 1'b1;
    else if (src_read && latch_on_event_enable)
      active_r <= sample_tick && read_tick_set;
    else
      active_r <= active_nxt;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      src_flags_r <= '0;
    else if (latched_hold && !src_read)
      src_flags_r <= src_flags_r;
    else if (sample_tick)
      src_flags_r <= masked_flags;
    else if (src_read && latch_on_event_enable)
      src_flags_r <= '0;
    else if (!latch_on_event_enable)
      src_flags_r <= src_flags_r & {axis_en, axis_en};
  end

  //------------------------------------------------------------
  // Register writes
  //------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_r <= CFG_RESET;
      ths_r <= THS_RESET;
      dbc_limit_r <= CNT_RESET;
      irq_ctrl_r <= IRQ_RESET[1:0];
    end
    else if (reg_wr)
    begin
      if (addr_hit(reg_addr, FALL_MOTION_CONFIG_ADDR))
        cfg_r <= reg_wdata & CFG_WRITE_MASK;
      if (addr_hit(reg_addr, FALL_MOTION_THRESHOLD_ADDR))
        ths_r <= reg_wdata;
      if (addr_hit(reg_addr, FALL_MOTION_DEBOUNCE_COUNT_ADDR))
        dbc_limit_r <= reg_wdata;
      if (addr_hit(reg_addr, FALL_MOTION_IRQ_CTRL_ADDR))
        irq_ctrl_r <= reg_wdata[1:0];
    end
  end

  //------------------------------------------------------------
  // Register reads
  //------------------------------------------------------------
  // Source image taken before the read-clear lands
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_r <= '0;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        FALL_MOTION_CONFIG_ADDR: reg_rdata_r <= cfg_r;
        // Disabled axes read zero even while a latched image is held
        FALL_MOTION_SOURCE_ADDR:
          reg_rdata_r <= {active_r, 1'b0,
                          src_flags_r.over[2] & axis_en[2], src_flags_r.neg[2] & axis_en[2],
                          src_flags_r.over[1] & axis_en[1], src_flags_r.neg[1] & axis_en[1],
                          src_flags_r.over[0] & axis_en[0], src_flags_r.neg[0] & axis_en[0]};
        FALL_MOTION_THRESHOLD_ADDR: reg_rdata_r <= ths_r;
        FALL_MOTION_DEBOUNCE_COUNT_ADDR: reg_rdata_r <= dbc_limit_r;
        FALL_MOTION_IRQ_CTRL_ADDR: reg_rdata_r <= {6'h00, irq_ctrl_r};
        default: reg_rdata_r <= '0;
      endcase
    end
    else
      reg_rdata_r <= '0;
  end

  assign reg_rdata = reg_rdata_r;

  //------------------------------------------------------------
  // Interrupt routing
  //------------------------------------------------------------
  assign irq_pin1 = active_r && fall_motion_irq_enable && fall_motion_irq_pin_route;
  assign irq_pin2 = active_r && fall_motion_irq_enable && !fall_motion_irq_pin_route;

endmodule : ffmd_event_flags

/* pkg/ffmd_pkg.sv */
// Package: register map, field positions and carrier types of the fall/motion flag block
package ffmd_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SAMPLE_W = 12;
  localparam int THS_W = 7;
  localparam int CNT_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] FALL_MOTION_CONFIG_ADDR = 8'h15;
  localparam logic [ADDR_W-1:0] FALL_MOTION_SOURCE_ADDR = 8'h16;
  localparam logic [ADDR_W-1:0] FALL_MOTION_THRESHOLD_ADDR = 8'h17;
  localparam logic [ADDR_W-1:0] FALL_MOTION_DEBOUNCE_COUNT_ADDR = 8'h18;
  localparam logic [ADDR_W-1:0] FALL_MOTION_IRQ_CTRL_ADDR = 8'h19;

  // Config fields
  localparam int CFG_LATCH_BIT = 7;
  localparam int CFG_COMBINE_BIT = 6;
  localparam int CFG_Z_EN_BIT = 5;
  localparam int CFG_Y_EN_BIT = 4;
  localparam int CFG_X_EN_BIT = 3;
  localparam logic [DATA_W-1:0] CFG_WRITE_MASK = 8'hF8;

  // Source fields
  localparam int SRC_ACTIVE_BIT = 7;

  // Threshold fields
  localparam int THS_MODE_BIT = 7;

  // Interrupt control fields
  localparam int IRQ_EN_BIT = 0;
  localparam int IRQ_ROUTE_BIT = 1;

  // Reset values
  localparam logic [DATA_W-1:0] CFG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] THS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] CNT_RESET = 8'h00;
  localparam logic [DATA_W-1:0] IRQ_RESET = 8'h00;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] z;
    logic signed [SAMPLE_W-1:0] y;
    logic signed [SAMPLE_W-1:0] x;
  } ffmd_sample_t;

  // Per axis flags, z in [2], x in [0]
  typedef struct packed {
    logic [2:0] over;
    logic [2:0] neg;
  } ffmd_axis_flags_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ffmd_bus_req_t;

endpackage : ffmd_pkg

/* testbench/ffmd_flags_sva.sv */
// Checker: port-level properties of the fall/motion flag block
`timescale 1ns/10ps
module ffmd_flags_sva
  import ffmd_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sample_tick,
  input ffmd_pkg::ffmd_sample_t sample,
  input wire logic [ffmd_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ffmd_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ffmd_pkg::DATA_W-1:0] reg_rdata,
  input wire logic irq_pin1,
  input wire logic irq_pin2
);
  logic [7:0] cfg_r;
  logic [1:0] irq_r;
  logic rd_src;
  logic cfg_wr;
  assign rd_src = reg_rd && reg_addr == FALL_MOTION_SOURCE_ADDR;
  assign cfg_wr = reg_wr && reg_addr == FALL_MOTION_CONFIG_ADDR;
  // Shadow copies of the written config and interrupt control registers
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n) cfg_r <= 8'h00;
    else if (cfg_wr) cfg_r <= reg_wdata;
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n) irq_r <= 2'h0;
    else if (reg_wr && reg_addr == FALL_MOTION_IRQ_CTRL_ADDR) irq_r <= reg_wdata[1:0];
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_cfg; cfg_wr ##2 reg_rd && reg_addr == FALL_MOTION_CONFIG_ADDR
    |=> reg_rdata == ($past(reg_wdata, 3) & CFG_WRITE_MASK); endproperty
  a_cfg: assert property (p_cfg) else $error("config readback wrong");
  property p_bit6; rd_src |=> !reg_rdata[6]; endproperty
  a_bit6: assert property (p_bit6) else $error("source bit 6 set");
  property p_mask; rd_src |=> (reg_rdata[5:0]
    & ~{{2{$past(cfg_r[5])}}, {2{$past(cfg_r[4])}}, {2{$past(cfg_r[3])}}}) == 6'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("disabled axis flag set");
  property p_excl; !(irq_pin1 && irq_pin2); endproperty
  a_excl: assert property (p_excl) else $error("both irq pins high");
  property p_pin1; irq_pin1 |-> irq_r == 2'h3; endproperty
  a_pin1: assert property (p_pin1) else $error("pin1 not gated");
  property p_pin2; irq_pin2 |-> irq_r == 2'h1; endproperty
  a_pin2: assert property (p_pin2) else $error("pin2 not gated");
  property p_ea; rd_src && irq_r[0] |=> reg_rdata[7] == $past(irq_pin1 || irq_pin2);
  endproperty
  a_ea: assert property (p_ea) else $error("event bit and irq differ");
  property p_clr; rd_src && cfg_r[7] && !sample_tick |=> !irq_pin1 && !irq_pin2;
  endproperty
  a_clr: assert property (p_clr) else $error("latched read kept event");
  sequence s_two_reads;
    rd_src && cfg_r[7] && !sample_tick ##1 !sample_tick ##1 rd_src && !sample_tick;
  endsequence
  property p_zero; s_two_reads |=> reg_rdata == 8'h00; endproperty
  a_zero: assert property (p_zero) else $error("source not cleared");
  c_pin1: cover property (irq_pin1);
  c_pin2: cover property (irq_pin2);
  c_latch: cover property (s_two_reads);
endmodule : ffmd_flags_sva

/* testbench/testbench.sv */
// Self-checking bench of the fall/motion flag block with a reference model
`timescale 1ns/10ps
module testbench;
  import ffmd_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic sample_tick = 1'b0;
  ffmd_sample_t sample = '0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic irq_pin1;
  logic irq_pin2;
  int failures = 0;
  int n_checks = 0;
  int seed = 37;
  int cfg;
  int thr;
  int x;
  int y;
  int z;
  int irq;
  logic [7:0] exp_src;
  logic [1:0] exp_irq;
  int tx[13] = '{257, -257, 257, 257, -257, 256, 256, -256, 257, -257, 257, 256, 257};
  int ea[13] = '{0, 0, 1, 1, 1, 1, 1, 0, 0, 0, 1, 0, 0};
  always #5 clock = ~clock;
  ffmd_event_flags i_ffmd_event_flags (.clock(clock), .rst_n(rst_n),
    .sample_tick(sample_tick), .sample(sample), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_pin1(irq_pin1), .irq_pin2(irq_pin2));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(n, e, reg_rdata);
  endtask : rd
  task automatic tk(input int a, input int b, input int c);
    @(posedge clock);
    sample_tick <= 1'b1;
    sample <= {12'(c), 12'(b), 12'(a)};
    @(posedge clock);
    sample_tick <= 1'b0;
  endtask : tk
  task automatic rst_dut();
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
  endtask : rst_dut
  // Reference: axis over/sign flags masked by enables, then AND or OR
  function automatic logic [7:0] fm(input int a, input int b, input int c);
    int v[3];
    logic [7:0] r;
    int hit;
    int low;
    v = '{a, b, c};
    r = 8'h00;
    hit = 0;
    low = 1;
    for (int i = 0; i < 3; i++)
    begin
      if (cfg[3 + i])
      begin
        r[2 * i + 1] = (v[i] < 0 ? -v[i] : v[i]) > thr * 16;
        r[2 * i] = v[i] < 0;
        hit |= r[2 * i + 1];
        low &= !r[2 * i + 1];
      end
    end
    r[7] = cfg[6] ? hit : (low && cfg[5:3] != 0);
    return r;
  endfunction : fm
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  // Whole run needs under a thousand cycles; allow ample margin
  initial
  begin
    #200000;
    failures++;
    results();
  end
  initial
  begin
    rst_dut();
    for (int a = 8'h15; a <= 8'h1A; a++)
      rd(8'(a), 8'h00, "reset value");
    wr(FALL_MOTION_CONFIG_ADDR, 8'hFF);
    rd(FALL_MOTION_CONFIG_ADDR, 8'hF8, "config readback");
    wr(FALL_MOTION_SOURCE_ADDR, 8'hFF);
    tk(0, 0, 0);
    rd(FALL_MOTION_SOURCE_ADDR, 8'h00, "source read-only");
    $display("test registers done");
    repeat (60)
    begin
      cfg = $random(seed) & 8'h78;
      thr = $random(seed) & 8'h7F;
      x = $random(seed) % 2048;
      y = $random(seed) % 2048;
      z = $random(seed) % 2048;
      wr(FALL_MOTION_CONFIG_ADDR, 8'(cfg));
      wr(FALL_MOTION_THRESHOLD_ADDR, 8'(thr | 8'h80));
      irq = $random(seed) & 3;
      wr(FALL_MOTION_IRQ_CTRL_ADDR, 8'(irq));
      exp_src = fm(x, y, z);
      exp_irq = {exp_src[7] && irq == 1, exp_src[7] && irq == 3};
      tk(x, y, z);
      #1 chk("irq pins", {6'h00, exp_irq}, {6'h00, irq_pin2, irq_pin1});
      rd(FALL_MOTION_SOURCE_ADDR, exp_src, "live source");
    end
    $display("test live flags done");
    rst_dut();
    cfg = 8'h48;
    thr = 16;
    wr(FALL_MOTION_CONFIG_ADDR, 8'h48);
    wr(FALL_MOTION_THRESHOLD_ADDR, 8'h10);
    wr(FALL_MOTION_DEBOUNCE_COUNT_ADDR, 8'h03);
    for (int i = 0; i < 13; i++)
    begin
      if (i == 8)
        wr(FALL_MOTION_THRESHOLD_ADDR, 8'h90);
      tk(tx[i], 0, 0);
      rd(FALL_MOTION_SOURCE_ADDR, {ea[i][0], 7'(fm(tx[i], 0, 0))}, "debounce");
    end
    $display("test debounce done");
    rst_dut();
    cfg = 8'hC8;
    wr(FALL_MOTION_CONFIG_ADDR, 8'hC8);
    wr(FALL_MOTION_THRESHOLD_ADDR, 8'h90);
    wr(FALL_MOTION_IRQ_CTRL_ADDR, 8'h03);
    tk(768, 0, 0);
    #1 chk("irq pin1", 8'h01, {6'h00, irq_pin2, irq_pin1});
    tk(-1024, 0, 0);
    rd(FALL_MOTION_SOURCE_ADDR, 8'h82, "latched source");
    rd(FALL_MOTION_SOURCE_ADDR, 8'h00, "cleared source");
    chk("irq cleared", 8'h00, {6'h00, irq_pin2, irq_pin1});
    wr(FALL_MOTION_DEBOUNCE_COUNT_ADDR, 8'h02);
    tk(768, 0, 0);
    tk(768, 0, 0);
    rd(FALL_MOTION_SOURCE_ADDR, 8'h82, "latched after count");
    tk(768, 0, 0);
    rd(FALL_MOTION_SOURCE_ADDR, 8'h02, "count restarted");
    $display("test latch done");
    results();
  end
endmodule : testbench
bind ffmd_event_flags ffmd_flags_sva i_ffmd_flags_sva (.clock(clock), .rst_n(rst_n),
  .sample_tick(sample_tick), .sample(sample), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_pin1(irq_pin1),
  .irq_pin2(irq_pin2));
